//--- bench/dai_event_src.sv
`timescale 1ns/1ns
`default_nettype none
module dai_event_src (
  input  wire logic                 clk,
  output var dai_pkg::dai_events_s  events,
  output logic [7:0]                lane_fifo_full,
  output logic [7:0]                lane_fifo_empty,
  output logic                      serial_link_enable
);
  initial begin
    events = 9'h000;
    lane_fifo_full = 8'h00;
    lane_fifo_empty = 8'h00;
    serial_link_enable = 1'b1;
  end
  task automatic drive(input logic [8:0] ev, input logic [7:0] full,
                       input logic [7:0] empty);
    @(posedge clk);
    events <= ev;
    lane_fifo_full <= full;
    lane_fifo_empty <= empty;
  endtask
  // A FIFO error only goes away when the link is taken down and back up.
  task automatic relink();
    @(posedge clk);
    serial_link_enable <= 1'b0;
    @(posedge clk);
    serial_link_enable <= 1'b1;
  endtask
endmodule
`default_nettype wire

//--- bench/test_dai_alarm_interrupt_status.sv
`timescale 1ns/1ns
`default_nettype none
module test_dac_alarm_interrupt_status;
  logic                 clk = 1'b0;
  logic                 rst = 1'b1;
  logic [11:0]          reg_addr = 12'h000;
  logic                 reg_wr = 1'b0;
  logic                 reg_rd = 1'b0;
  logic [7:0]           reg_wdata = 8'h00;
  logic [7:0]           reg_rdata;
  dai_pkg::dai_events_s events;
  logic [7:0]           full;
  logic [7:0]           empty;
  logic                 link_en;
  logic                 irq_n;
  int                   fails = 0;
  int                   checks = 0;
  always #5 clk = ~clk;
  dai_event_src i_src (.clk(clk), .events(events), .lane_fifo_full(full),
    .lane_fifo_empty(empty), .serial_link_enable(link_en));
  dai_irq_status #(.LANES(8)) i_dut (.clk(clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .events(events),
    .lane_fifo_full(full), .lane_fifo_empty(empty),
    .serial_link_enable(link_en), .irq_n(irq_n));
  task automatic give_verdict();
    if (fails == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", exp, reg_rdata);
  endtask
  task automatic irq(input logic exp);
    repeat (3) @(posedge clk);
    #1;
    chk("irq_n", {7'h00, exp}, {7'h00, irq_n});
  endtask
  initial begin
    #20000;
    fails++;
    give_verdict();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(12'h022, 8'h00);
    rd(12'h023, 8'h00);
    irq(1'b1);
    // Live reporting first: status follows inputs, except the FIFO error that holds until relink, and never interrupts.
    i_src.drive(9'h1FF, 8'h08, 8'h00);
    irq(1'b1);
    rd(12'h026, 8'h07);
    rd(12'h023, 8'hFE);
    rd(12'h30C, 8'h08);
    i_src.drive(9'h000, 8'h00, 8'h00);
    rd(12'h026, 8'h00);
    rd(12'h023, 8'h02);
    i_src.relink();
    irq(1'b1);
    rd(12'h023, 8'h00);
    wr(12'h020, 8'hFE);
    wr(12'h022, 8'h07);
    rd(12'h022, 8'h07);
    // Held levels must latch once; dropping them must not clear status.
    i_src.drive(9'h1FF, 8'h00, 8'h01);
    irq(1'b0);
    rd(12'h30D, 8'h01);
    i_src.drive(9'h000, 8'h00, 8'h00);
    irq(1'b0);
    rd(12'h023, 8'hFE);
    rd(12'h026, 8'h07);
    wr(12'h026, 8'h07);
    rd(12'h026, 8'h00);
    irq(1'b0);
    wr(12'h023, 8'hFE);
    rd(12'h023, 8'h00);
    irq(1'b1);
    i_src.relink();
    rd(12'h100, 8'h00);
    give_verdict();
  end
endmodule
`default_nettype wire

//--- core/dai_cfg.svh
// What this block does
// R1: Channel B rotate latch mode bit 2 set: rising rotate latches, pulls interrupt low.
// R2: Channel B rotate latch mode clear: status follows live rotate condition, no latch.
// R3: Channel B window latch mode bit 1: latch rising event, else show live state.
// R4: Channel B tripped latch mode bit 0: latch rising event, else show live state.
// R5: The three channel B latch mode bits are read/write and reset to zero.
// R6: Status bit 7 is calibration passed, live or latching per its mode bit.
// R7: Status bit 6 is calibration failed, live or latching per its mode bit.
// R8: Status bit 5 is converter PLL lock lost, live or latching, interrupts.
// R9: Status bit 4 is converter PLL locked, live or latching, interrupts.
// R10: Status bit 3 is serdes PLL lock lost, live or latching, interrupts.
// R11: Status bit 2 is serdes PLL locked, live or latching, interrupts.
// R12: Status bit 1 is lane FIFO error, live or latching per its mode bit.
// R13: Lane FIFO error rises when any lane FIFO is full or empty.
// R14: Lane FIFO error persists until the serial link is disabled and re-enabled.
// R15: Per-lane FIFO full and empty flags read in two separate registers.
// R16: A latched status bit stays set until the host writes one to it.
// R17: Interrupt output returns high once no latch-mode status bit remains set.
// R18: Rising edges compare each event with its value from the previous clock.
`ifndef DAI_CFG_SVH
`define DAI_CFG_SVH
`define DAI_ADDR_W          12
`define DAI_ADDR_MODE_MAIN  12'h020
`define DAI_ADDR_MODE_CHB   12'h022
`define DAI_ADDR_STAT_MAIN  12'h023
`define DAI_ADDR_STAT_CHB   12'h026
`define DAI_ADDR_FIFO_FULL  12'h30C
`define DAI_ADDR_FIFO_EMPTY 12'h30D
`define DAI_MAIN_LSB        1
`define DAI_MAIN_MSB        7
`define DAI_CHB_W           3
`define DAI_EV_W            10
`define DAI_RESET_BYTE      8'h00
`endif

//--- core/dai_irq_status.sv
`timescale 1ns/1ns
`default_nettype none
`include "dai_cfg.svh"
module dai_irq_status #(
  parameter int LANES = 8
) (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic [`DAI_ADDR_W-1:0]    reg_addr,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  input  wire logic [7:0]                reg_wdata,
  output logic      [7:0]                reg_rdata,
  input  wire dai_pkg::dai_events_s      events,
  input  wire logic [LANES-1:0]          lane_fifo_full,
  input  wire logic [LANES-1:0]          lane_fifo_empty,
  input  wire logic                      serial_link_enable,
  output logic                           irq_n
);

  dai_pkg::dai_state_s s_q;
  dai_pkg::dai_state_s s_d;

  logic [`DAI_EV_W-1:0] live;
  logic [`DAI_EV_W-1:0] mode;
  logic [`DAI_EV_W-1:0] clr;
  logic [`DAI_EV_W-1:0] rise;
  logic                 fifo_any;
  logic                 wr_stat_main;
  logic                 wr_stat_chb;

  assign fifo_any = (|lane_fifo_full) | (|lane_fifo_empty); // see R13
  assign wr_stat_main = reg_wr && (reg_addr == `DAI_ADDR_STAT_MAIN);
  assign wr_stat_chb  = reg_wr && (reg_addr == `DAI_ADDR_STAT_CHB);

  always_comb begin
    live = {events.calibration_passed,       // see R6
            events.calibration_failed,       // see R7
            events.conv_pll_lock_lost,       // see R8
            events.conv_pll_locked,          // see R9
            events.serdes_pll_lock_lost,     // see R10
            events.serdes_pll_locked,        // see R11
            s_q.fifo_err,                    // see R12
            events.chb_align_rotated,        // see R1
            events.chb_phase_out_of_window,  // see R3
            events.chb_align_tripped};       // see R4
    mode = {s_q.mode_main[`DAI_MAIN_MSB:`DAI_MAIN_LSB], s_q.mode_chb};
    clr = '0;
    if (wr_stat_main) begin
      clr[`DAI_EV_W-1:`DAI_CHB_W] =
        reg_wdata[`DAI_MAIN_MSB:`DAI_MAIN_LSB]; // see R16
    end
    if (wr_stat_chb) begin
      clr[`DAI_CHB_W-1:0] = reg_wdata[`DAI_CHB_W-1:0]; // see R16
    end
  end

  // Edge against the previous sample, so a held level latches once.
  assign rise = live & ~s_q.ev_prev; // see R18

  always_comb begin
    s_d = s_q;
    s_d.ev_prev = live; // see R18
    // Error sticks while the link is up; dropping the enable is the
    // only way out, so software must cycle the link to recover.
    s_d.fifo_err = serial_link_enable & (s_q.fifo_err | fifo_any); // see R14
    for (int i = 0; i < `DAI_EV_W; i++) begin
      if (mode[i]) begin
        // Set beats clear when both land on the same edge.
        s_d.stat[i] = (s_q.stat[i] & ~clr[i]) | rise[i]; // see R1 R16
      end else begin
        s_d.stat[i] = live[i]; // see R2
      end
    end
    if (reg_wr) begin
      unique case (reg_addr)
        `DAI_ADDR_MODE_MAIN: begin
          s_d.mode_main = {reg_wdata[`DAI_MAIN_MSB:`DAI_MAIN_LSB], 1'b0};
        end
        `DAI_ADDR_MODE_CHB: begin
          s_d.mode_chb = reg_wdata[`DAI_CHB_W-1:0]; // see R5
        end
        default: begin
        end
      endcase
    end
    s_d.irq_n = ~(|(s_d.stat & mode)); // see R17
    s_d.rdata = `DAI_RESET_BYTE;
    if (reg_rd) begin
      unique case (reg_addr)
        `DAI_ADDR_MODE_MAIN: s_d.rdata = s_q.mode_main;
        `DAI_ADDR_MODE_CHB:  s_d.rdata = {5'h00, s_q.mode_chb}; // see R5
        `DAI_ADDR_STAT_MAIN: begin
          s_d.rdata = {s_q.stat[`DAI_EV_W-1:`DAI_CHB_W], 1'b0};
        end
        `DAI_ADDR_STAT_CHB: begin
          s_d.rdata = {5'h00, s_q.stat[`DAI_CHB_W-1:0]};
        end
        `DAI_ADDR_FIFO_FULL:  s_d.rdata = 8'(lane_fifo_full);  // see R15
        `DAI_ADDR_FIFO_EMPTY: s_d.rdata = 8'(lane_fifo_empty); // see R15
        default: s_d.rdata = `DAI_RESET_BYTE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q       <= '0;
      s_q.irq_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign irq_n     = s_q.irq_n;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  latch_holds_a: assert property ( // see R16
    s_q.mode_chb[2] && s_q.stat[2] && !(wr_stat_chb && reg_wdata[2])
    && $stable(s_q.mode_chb) |=> s_q.stat[2])
    else $error("Latched rotate bit dropped without a clear.");

  rotate_latch_a: assert property ( // see R1
    s_q.mode_chb[2] && events.chb_align_rotated && !s_q.ev_prev[2]
    |=> s_q.stat[2] && !irq_n)
    else $error("Rotate edge did not latch and raise the interrupt.");

  rotate_live_a: assert property ( // see R2
    !s_q.mode_chb[2] ##1 !s_q.mode_chb[2]
    |-> s_q.stat[2] == $past(events.chb_align_rotated))
    else $error("Live rotate status does not follow its input.");

  window_latch_a: assert property ( // see R3
    s_q.mode_chb[1] && rise[1] |=> s_q.stat[1])
    else $error("Window edge did not latch.");

  trip_latch_a: assert property ( // see R4
    s_q.mode_chb[0] && rise[0] |=> s_q.stat[0])
    else $error("Tripped edge did not latch.");

  mode_write_a: assert property ( // see R5
    reg_wr && reg_addr == `DAI_ADDR_MODE_CHB
    |=> s_q.mode_chb == $past(reg_wdata[2:0]))
    else $error("Channel B mode write not stored.");

  calibration_passed_latch_a: assert property ( // see R6
    s_q.mode_main[7] && rise[9] |=> s_q.stat[9] && !irq_n)
    else $error("Calibration pass edge did not latch.");

  fifo_sticky_a: assert property ( // see R14
    s_q.fifo_err && serial_link_enable |=> s_q.fifo_err)
    else $error("Lane FIFO error cleared while link enabled.");

  fifo_raise_a: assert property ( // see R13
    serial_link_enable && fifo_any |=> s_q.fifo_err)
    else $error("Lane FIFO error not raised.");

  fifo_read_a: assert property ( // see R15
    reg_rd && reg_addr == `DAI_ADDR_FIFO_EMPTY
    |=> reg_rdata == 8'($past(lane_fifo_empty)))
    else $error("FIFO empty register read wrong.");

  irq_release_a: assert property ( // see R17
    !irq_n && !(|(s_q.stat & mode)) && !(|(rise & mode)) |=> irq_n)
    else $error("Interrupt stuck low with nothing latched.");

  single_latch_a: assert property ( // see R18
    s_q.mode_chb[0] && s_q.ev_prev[0] && events.chb_align_tripped
    && !s_q.stat[0] |=> !s_q.stat[0])
    else $error("Held level latched a second time.");

  cov_irq_c:   cover property (irq_n ##1 !irq_n);
  cov_clear_c: cover property (s_q.stat[2] && s_q.mode_chb[2]
                               ##1 !s_q.stat[2]);
  cov_fifo_c:  cover property (s_q.fifo_err ##1 !s_q.fifo_err);
  cov_race_c:  cover property (rise[9] && clr[9] && s_q.mode_main[7]);

endmodule
`default_nettype wire

//--- core/dai_pkg.sv
package dai_pkg;
  typedef struct packed {
    logic [7:0] addr_lo;
  } dai_unused_s;

  // Event vector order: [9:3] main status bits 7..1, [2:0] channel B 2..0.
  typedef struct packed {
    logic [7:0] mode_main;
    logic [2:0] mode_chb;
    logic [9:0] stat;
    logic [9:0] ev_prev;
    logic       fifo_err;
    logic [7:0] rdata;
    logic       irq_n;
  } dai_state_s;

  typedef struct packed {
    logic calibration_passed;
    logic calibration_failed;
    logic conv_pll_lock_lost;
    logic conv_pll_locked;
    logic serdes_pll_lock_lost;
    logic serdes_pll_locked;
    logic chb_align_rotated;
    logic chb_phase_out_of_window;
    logic chb_align_tripped;
  } dai_events_s;
endpackage
